//--- alarm_exc.sv
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module alarm_exc #(
    parameter int HOLD_CYCLES = alarm_exc_pkg::HOLD_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  alarm_detect_code,
    input  wire logic        alarm_detect,
    input  wire logic        alarm_reset_pin,
    input  wire logic        key_up,
    input  wire logic        key_down,
    input  wire logic        alarm_screen,
    input  wire logic        position_preset,
    output logic [7:0]       display_item,
    output logic             irq
);
    import alarm_exc_pkg::*;

    // ****************************************
    // functions
    // ****************************************
    function automatic logic fc_supported(input logic [7:0] fc);
        fc_supported = (fc == 8'h01) || (fc == 8'h03) || (fc == 8'h05) ||
                       (fc == 8'h08) || (fc == 8'h0f) || (fc == 8'h10);
    endfunction

    function automatic logic alarm_resettable(input logic [7:0] c);
        case (c)
            8'h01, 8'h02, 8'h12, 8'h03, 8'h05, 8'h0d, 8'h0f, 8'h10,
            8'h21, 8'h04, 8'h25, 8'h26, 8'h20, 8'h2f, 8'h2e:
                alarm_resettable = 1'b1;
            default: alarm_resettable = 1'b0;
        endcase
    endfunction

    function automatic logic alarm_presettable(input logic [7:0] c);
        alarm_presettable = (c == 8'h28) || (c == 8'h29) ||
                            (c == 8'h2a) || (c == 8'h2b);
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        crc_byte = r;
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [4:0] sync1_q, sync2_q, sync1_d;
    logic       rst_pin_s, up_s, down_s, screen_s, preset_s;
    assign sync1_d = {alarm_reset_pin, key_up, key_down,
                      alarm_screen, position_preset};
    assign {rst_pin_s, up_s, down_s, screen_s, preset_s} = sync2_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync1_q;
        end
    end

    // ****************************************
    // axi4-lite slave
    // ****************************************
    logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    logic        wr_fire, rd_fire;
    logic [7:0]  query_fc_q, query_fc_d, station_q, station_d;
    check_s      check_q, check_d;
    logic        go;
    logic [7:0]  pos_q, pos_d, disp_cfg_q, disp_cfg_d;
    logic [2:0]  msk_q, msk_d, st_q, st_d;
    logic [7:0]  alarm_q, alarm_d;
    logic [7:0]  exc_fc_q, exc_fc_d, exc_code_q, exc_code_d;
    logic        exc_valid_q, exc_valid_d;
    logic [15:0] crc_q, crc_d;
    exc_state_e  ex_q, ex_d;
    logic [1:0]  crc_idx_q, crc_idx_d;
    pos_dec_s    dec;
    assign wr_fire = aw_q && w_q && !bv_q;
    assign rd_fire = s_axi_arvalid && !rv_q;
    always_comb begin
        {aw_d, w_d, bv_d, rv_d} = {aw_q, w_q, bv_q, rv_q};
        {br_d, rr_d, awa_d} = {br_q, rr_q, awa_q};
        {wd_d, rd_d} = {wd_q, rd_q};
        {query_fc_d, station_d, check_d} = {query_fc_q, station_q, check_q};
        {pos_d, disp_cfg_d, msk_d} = {pos_q, disp_cfg_q, msk_q};
        go = 1'b0;
        if (s_axi_awvalid && !aw_q) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
        end
        if (wr_fire) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = RESP_OKAY;
            if (awa_q == REG_QUERY) begin
                query_fc_d = wd_q[7:0];
                station_d = wd_q[15:8];
            end else if (awa_q == REG_CHECK) begin
                check_d = wd_q[4:0];
                go = wd_q[8];
            end else if (awa_q == REG_POS) begin
                pos_d = wd_q[7:0] & 8'h37; // bits 7, 6 and 3 fixed 0
            end else if (awa_q == REG_DISP) begin
                disp_cfg_d = wd_q[7:0];
            end else if (awa_q == REG_IRQ_MSK) begin
                msk_d = wd_q[2:0];
            end else if (awa_q == REG_EXC || awa_q == REG_CRC ||
                         awa_q == REG_POSDEC || awa_q == REG_ALARM ||
                         awa_q == REG_IRQ_ST) begin
                br_d = RESP_OKAY; // read-only, write ignored
            end else begin
                br_d = RESP_SLVERR;
            end
        end else if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        if (rd_fire) begin
            rv_d = 1'b1;
            rr_d = RESP_OKAY;
            rd_d = 32'h0000_0000;
            if (s_axi_araddr == REG_QUERY) begin
                rd_d = {16'h0000, station_q, query_fc_q};
            end else if (s_axi_araddr == REG_CHECK) begin
                rd_d = {27'h0, check_q};
            end else if (s_axi_araddr == REG_EXC) begin
                rd_d = {7'h00, exc_valid_q, exc_code_q, exc_fc_q, station_q};
            end else if (s_axi_araddr == REG_CRC) begin
                rd_d = {16'h0000, crc_q[15:8], crc_q[7:0]};
            end else if (s_axi_araddr == REG_POS) begin
                rd_d = {24'h0, pos_q};
            end else if (s_axi_araddr == REG_POSDEC) begin
                rd_d = {27'h0, dec};
            end else if (s_axi_araddr == REG_ALARM) begin
                rd_d = {24'h000000, alarm_q};
            end else if (s_axi_araddr == REG_DISP) begin
                rd_d = {24'h0, disp_cfg_q};
            end else if (s_axi_araddr == REG_IRQ_ST) begin
                rd_d = {29'h0, st_q};
            end else if (s_axi_araddr == REG_IRQ_MSK) begin
                rd_d = {29'h0, msk_q};
            end else begin
                rr_d = RESP_SLVERR;
            end
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {aw_q, w_q, bv_q, rv_q} <= 4'h0;
            {br_q, rr_q} <= {RESP_OKAY, RESP_OKAY};
            {awa_q, wd_q, rd_q} <= 72'h0;
            {query_fc_q, station_q, check_q} <= 21'h0;
            pos_q <= POS_RST;
            disp_cfg_q <= DISP_RST;
            msk_q <= 3'h0;
        end else begin
            {aw_q, w_q, bv_q, rv_q} <= {aw_d, w_d, bv_d, rv_d};
            {br_q, rr_q, awa_q} <= {br_d, rr_d, awa_d};
            {wd_q, rd_q} <= {wd_d, rd_d};
            {query_fc_q, station_q} <= {query_fc_d, station_d};
            check_q <= check_d;
            {pos_q, disp_cfg_q, msk_q} <= {pos_d, disp_cfg_d, msk_d};
        end
    end
    // skid-free: ready only while the channel slot is empty
    assign s_axi_awready = !aw_q;
    assign s_axi_wready  = !w_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rresp   = rr_q;
    assign s_axi_rdata   = rd_q;

    // ****************************************
    // positioning status decode
    // ****************************************
    always_comb begin
        dec.mcode_after  = pos_q[POS_MTIME];
        dec.mcode_en     = pos_q[POS_MEN];
        dec.step         = pos_q[POS_STEP_L +: 2];
        dec.step_illegal = (pos_q[POS_STEP_L +: 2] == STEP_ILL);
    end

    // ****************************************
    // exception response builder
    // ****************************************
    logic [7:0] crc_in;
    always_comb begin
        ex_d = ex_q;
        exc_fc_d = exc_fc_q;
        exc_code_d = exc_code_q;
        exc_valid_d = exc_valid_q;
        crc_d = crc_q;
        crc_idx_d = crc_idx_q;
        crc_in = station_q;
        case (ex_q)
            EX_IDLE: begin
                if (go) begin
                    exc_valid_d = 1'b1;
                    exc_fc_d = query_fc_q | FC_ERR_BIT;
                    if (!fc_supported(query_fc_q)) begin
                        exc_code_d = EXC_FC;
                    end else if (check_d.addr_unknown ||
                                 check_d.addr_read_only) begin
                        exc_code_d = EXC_ADDR;
                    end else if (check_d.count_bad ||
                                 check_d.byte_count_bad ||
                                 check_d.value_bad) begin
                        exc_code_d = EXC_DATA;
                    end else begin
                        exc_valid_d = 1'b0; // normal path, no exception
                    end
                    crc_d = CRC_INIT;
                    crc_idx_d = 2'd0;
                    ex_d = EX_CRC;
                end
            end
            EX_CRC: begin
                if (crc_idx_q == 2'd0) begin
                    crc_in = station_q;
                end else if (crc_idx_q == 2'd1) begin
                    crc_in = exc_fc_q;
                end else begin
                    crc_in = exc_code_q;
                end
                crc_d = crc_byte(crc_q, crc_in);
                crc_idx_d = crc_idx_q + 2'd1;
                if (crc_idx_q == 2'd2) begin
                    ex_d = EX_DONE;
                end
            end
            default: begin
                ex_d = EX_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ex_q <= EX_IDLE;
            exc_fc_q <= 8'h00;
            exc_code_q <= 8'h00;
            exc_valid_q <= 1'b0;
            crc_q <= CRC_INIT;
            crc_idx_q <= 2'd0;
        end else begin
            ex_q <= ex_d;
            exc_fc_q <= exc_fc_d;
            exc_code_q <= exc_code_d;
            exc_valid_q <= exc_valid_d;
            crc_q <= crc_d;
            crc_idx_q <= crc_idx_d;
        end
    end

    // ****************************************
    // alarm latch and clearing
    // ****************************************
    logic        rst_pin_dly_q, rst_pin_dly_d;
    logic [31:0] hold_q, hold_d;
    logic        key_fired_q, key_fired_d;
    logic        reset_req, clr_ok, preset_clr, both_keys;
    logic [7:0]  disp_q, disp_d;
    logic [2:0]  ev;

    assign both_keys = up_s && down_s && screen_s;
    always_comb begin
        rst_pin_dly_d = rst_pin_s;
        hold_d = both_keys ? ((hold_q < HOLD_CYCLES) ? hold_q + 32'd1
                                                      : hold_q)
                           : 32'd0;
        key_fired_d = both_keys && (key_fired_q || hold_d >= HOLD_CYCLES);
        reset_req = (rst_pin_dly_q && !rst_pin_s) ||
                    (both_keys && !key_fired_q &&
                     hold_d >= HOLD_CYCLES);
        clr_ok = reset_req && alarm_resettable(alarm_q);
        preset_clr = preset_s && alarm_presettable(alarm_q);
        alarm_d = alarm_q;
        if (alarm_q == ALARM_NONE) begin
            if (alarm_detect) begin
                alarm_d = alarm_detect_code;
            end
        end else if (clr_ok || preset_clr) begin
            alarm_d = ALARM_NONE;
        end
        disp_d = clr_ok ? disp_cfg_q : disp_q;
        ev = {ex_q == EX_CRC && crc_idx_q == 2'd2 && exc_valid_q,
              clr_ok || preset_clr,
              alarm_q == ALARM_NONE && alarm_detect};
        st_d = (rd_fire && s_axi_araddr == REG_IRQ_ST) ? ev : (st_q | ev);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {rst_pin_dly_q, key_fired_q, irq} <= 3'h0;
            hold_q <= 32'd0;
            alarm_q <= ALARM_NONE;
            disp_q <= DISP_RST;
            st_q <= 3'h0;
        end else begin
            {rst_pin_dly_q, key_fired_q} <= {rst_pin_dly_d, key_fired_d};
            hold_q <= hold_d;
            alarm_q <= alarm_d;
            disp_q <= disp_d;
            st_q <= st_d;
            irq <= |(st_d & msk_q);
        end
    end
    assign display_item = disp_q;

    // ****************************************
    // assertions
    // ****************************************
    property p_exc_fc;
        @(posedge aclk) disable iff (!aresetn)
        (ex_q == EX_IDLE && go) |=> exc_fc_q == ($past(query_fc_q) | 8'h80);
    endproperty
    a_exc_fc: assert property (p_exc_fc) else $error("fc msb not set");
    property p_bad_fc;
        @(posedge aclk) disable iff (!aresetn)
        (ex_q == EX_IDLE && go && !fc_supported(query_fc_q))
        |=> exc_code_q == 8'h01 && exc_valid_q;
    endproperty
    a_bad_fc: assert property (p_bad_fc) else $error("bad fc code");
    property p_addr;
        @(posedge aclk) disable iff (!aresetn)
        (ex_q == EX_IDLE && go && fc_supported(query_fc_q) &&
         check_d.addr_unknown) |=> exc_code_q == 8'h02;
    endproperty
    a_addr: assert property (p_addr) else $error("addr code");
    property p_crc_done;
        @(posedge aclk) disable iff (!aresetn)
        (ex_q == EX_IDLE && go) |=> ex_q == EX_CRC [*3] ##1 ex_q == EX_DONE;
    endproperty
    a_crc_done: assert property (p_crc_done) else $error("crc timing");
    property p_hold_alarm;
        @(posedge aclk) disable iff (!aresetn)
        (alarm_q != 8'h00 && !clr_ok && !preset_clr) |=> $stable(alarm_q);
    endproperty
    a_hold_alarm: assert property (p_hold_alarm) else $error("alarm moved");
    property p_no_clear;
        @(posedge aclk) disable iff (!aresetn)
        (alarm_q == 8'h08 && !preset_s) |=> alarm_q == 8'h08;
    endproperty
    a_no_clear: assert property (p_no_clear) else $error("fatal cleared");
    property p_pin_clear;
        @(posedge aclk) disable iff (!aresetn)
        (rst_pin_dly_q && !rst_pin_s && alarm_q == 8'h01) |=> alarm_q == 8'h00;
    endproperty
    a_pin_clear: assert property (p_pin_clear) else $error("no clear");
    property p_disp;
        @(posedge aclk) disable iff (!aresetn)
        clr_ok |=> display_item == $past(disp_cfg_q);
    endproperty
    a_disp: assert property (p_disp) else $error("display item");
    c_exc: cover property (@(posedge aclk) ex_q == EX_DONE && exc_valid_q);
    c_clear: cover property (@(posedge aclk) clr_ok);
    c_preset: cover property (@(posedge aclk) preset_clr);
endmodule
`default_nettype wire

//--- alarm_exc_pkg.sv
// How it works
// - status bit 5: 0 issues m code at start, 1 after positioning done
// - status bit 4: 1 enables m code output, 0 disables it
// - status bits 2:1: none, continue, cycle end; 11 is illegal
// - a query that cannot be processed gets an exception response
// - exception frame: station, fc, code, crc low then high
// - exception fc is the query fc with bit 7 set
// - code 01h for any fc outside 01h,03h,05h,08h,0fh,10h
// - code 02h for unknown register or write to read-only register
// - code 02h for unknown coil or write to read-only coil
// - code 03h for bad register count, byte count or write value
// - code 03h for bad coil count, byte count or single coil value
// - a resettable alarm clears on release of an alarm-reset pulse
// - up and down keys held one second on alarm screen resets
// - overcurrent, overspeed, overload and similar alarms clear on reset
// - encoder, circuit, memory and similar alarms stay until power cycle
// - absolute data lost and multiturn overflow clear on position preset
// - after a successful reset the display returns to the initial item
// - alarm code sits in low byte of a zero-filled 32-bit word
`default_nettype none
package alarm_exc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] REG_QUERY   = 8'h00; // rw: fc, station
    localparam logic [7:0] REG_CHECK   = 8'h04; // rw: check flags, go (go reads back 0)
    localparam logic [7:0] REG_EXC     = 8'h08; // r: exception frame info
    localparam logic [7:0] REG_CRC     = 8'h0c; // r: crc bytes
    localparam logic [7:0] REG_POS     = 8'h10; // rw: positioning status
    localparam logic [7:0] REG_POSDEC  = 8'h14; // r: decoded status
    localparam logic [7:0] REG_ALARM   = 8'h18; // r: present alarm code
    localparam logic [7:0] REG_DISP    = 8'h1c; // rw: initial display item
    localparam logic [7:0] REG_IRQ_ST  = 8'h20; // r, read clears
    localparam logic [7:0] REG_IRQ_MSK = 8'h24; // rw
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // field positions and codes
    // ****************************************
    localparam int          POS_MTIME  = 5;
    localparam int          POS_MEN    = 4;
    localparam int          POS_STEP_L = 1;
    localparam logic [7:0]  POS_RST    = 8'h01;
    localparam logic [1:0]  STEP_NONE  = 2'h0;
    localparam logic [1:0]  STEP_ILL   = 2'h3;
    localparam logic [7:0]  EXC_FC     = 8'h01;
    localparam logic [7:0]  EXC_ADDR   = 8'h02;
    localparam logic [7:0]  EXC_DATA   = 8'h03;
    localparam logic [7:0]  FC_ERR_BIT = 8'h80;
    localparam logic [15:0] CRC_INIT   = 16'hffff;
    localparam logic [15:0] CRC_POLY   = 16'ha001;
    localparam logic [7:0]  ALARM_NONE = 8'h00;
    localparam logic [7:0]  DISP_RST   = 8'h00;
    // ****************************************
    // timing
    // ****************************************
    localparam int          CLK_MHZ    = 200;
    localparam int          HOLD_MS    = 1000;
    localparam int          HOLD_CYC   = HOLD_MS * CLK_MHZ * 1000;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        EX_IDLE = 2'b00,
        EX_CRC  = 2'b01,
        EX_DONE = 2'b10
    } exc_state_e;
    typedef struct packed {
        logic addr_unknown;
        logic addr_read_only;
        logic count_bad;
        logic byte_count_bad;
        logic value_bad;
    } check_s;
    typedef struct packed {
        logic       mcode_after;
        logic       mcode_en;
        logic [1:0] step;
        logic       step_illegal;
    } pos_dec_s;
endpackage
`default_nettype wire

//--- axi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module axi_host_model (
    input  wire logic        aclk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // ****************************************
    // host software side of the register bus
    // ****************************************
    // ready lines stay high, so each answer is taken in its first valid cycle and drops after it
    initial begin
        {awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
        bready = 1'b1;
        rready = 1'b1;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        bit aw;
        bit w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (awready) aw = 1'b0;
            if (wready) w = 1'b0;
            awvalid <= aw;
            wvalid <= w;
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import alarm_exc_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, det = 1'b0, rst_pin = 1'b0;
    logic kup = 1'b0, kdn = 1'b0, scr = 1'b0, pre = 1'b0;
    logic [7:0] adc = 8'h00, awaddr, araddr, disp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, irq;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, rr;
    logic [31:0] wdata, rdata, rv;
    logic [23:0] f;
    logic [15:0] c;
    int miscompares = 0;
    int checks = 0;
    logic [7:0] alm [27] = '{8'h01, 8'h02, 8'h12, 8'h03, 8'h05, 8'h0d,
        8'h0f, 8'h10, 8'h21, 8'h04, 8'h25, 8'h26, 8'h20, 8'h2f, 8'h2e,
        8'h06, 8'h07, 8'h08, 8'h09, 8'h0b, 8'h0e, 8'h24, 8'h13, 8'h28,
        8'h29, 8'h2a, 8'h2b};
    // fc, check flags, expected code; flags mixed in to probe priority
    logic [23:0] exc [14] = '{24'h070001, 24'h031002, 24'h100802,
        24'h011002, 24'h050802, 24'h0f0802, 24'h030403, 24'h100203,
        24'h100103, 24'h010403, 24'h0f0203, 24'h050103, 24'h2b1f01,
        24'h031c02};
    logic [15:0] pd [4] = '{16'h361f, 16'h2212, 16'h140c, 16'h0100};
    always #2.5 aclk = ~aclk;
    alarm_exc #(.HOLD_CYCLES(10)) dut_u (.aclk, .aresetn,
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .alarm_detect_code(adc), .alarm_detect(det),
        .alarm_reset_pin(rst_pin), .key_up(kup), .key_down(kdn),
        .alarm_screen(scr), .position_preset(pre), .display_item(disp),
        .irq);
    axi_host_model host_u (.aclk, .awaddr, .awvalid, .awready, .wdata,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready);
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic chk32(input string s, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk1(input string s, input logic e, g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", s, e, g);
        end
    endtask
    task automatic rd_chk(input string s, input logic [7:0] a,
                          input logic [31:0] e);
        host_u.rd(a, rv, rr);
        chk32(s, e, rv);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.wr(a, d, rr);
        chk32("bresp", {30'h0, RESP_OKAY}, {30'h0, rr});
    endtask
    task automatic power_cycle;
        aresetn <= 1'b0;
        cyc(8);
        aresetn <= 1'b1;
        cyc(1);
    endtask
    task automatic raise(input logic [7:0] code);
        adc <= code;
        det <= 1'b1;
        cyc(1);
        det <= 1'b0;
        cyc(4);
    endtask
    task automatic pulse(input bit preset);
        {pre, rst_pin} <= preset ? 2'b10 : 2'b01;
        cyc(4);
        {pre, rst_pin} <= 2'b00;
        cyc(5);
    endtask
    function automatic logic [15:0] crc3(input logic [23:0] b);
        logic [15:0] r;
        r = CRC_INIT;
        for (int k = 0; k < 3; k++) begin
            r = r ^ {8'h00, b[23-8*k -: 8]};
            for (int j = 0; j < 8; j++)
                r = r[0] ? (r >> 1) ^ CRC_POLY : r >> 1;
        end
        return r;
    endfunction
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        @(posedge aclk);
        power_cycle();
        rd_chk("pos", REG_POS, 32'h01);
        rd_chk("posdec", REG_POSDEC, 32'h00);
        for (int i = 0; i < 4; i++) begin
            wr(REG_POS, {24'h0, pd[i][15:8]});
            rd_chk("posdec", REG_POSDEC, {24'h0, pd[i][7:0]});
        end
        host_u.rd(8'h30, rv, rr);
        chk32("resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
        host_u.wr(8'h30, 32'h0, rr);
        chk32("bresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
        for (int i = 0; i < 16; i++) begin
            f = i < 14 ? exc[i] : {i == 14 ? 8'h03 : 8'h08, 16'h0};
            wr(REG_QUERY, {16'h0, 8'(i + 17), f[23:16]});
            wr(REG_CHECK, {23'h0, 1'b1, f[15:8]});
            cyc(4);
            f = {8'(i + 17), f[23:16] | FC_ERR_BIT, f[7:0]};
            c = crc3(f);
            host_u.rd(REG_EXC, rv, rr);
            if (i < 14) chk32("exc", {8'h01, f[7:0], f[15:8], f[23:16]}, rv);
            else chk1("valid", 1'b0, rv[24]);
            if (i < 14) rd_chk("crc", REG_CRC, {16'h0, c});
        end
        for (int i = 0; i < 27; i++) begin
            raise(alm[i]);
            pulse(1'b0);
            rd_chk("alarm", REG_ALARM, i < 15 ? 32'h0 : {24'h0, alm[i]});
            power_cycle();
        end
        for (int i = 0; i < 5; i++) begin
            raise(i < 4 ? 8'(8'h28 + i) : 8'h08);
            pulse(1'b1);
            rd_chk("preset", REG_ALARM, i < 4 ? 32'h0 : 32'h08);
            power_cycle();
        end
        raise(8'h01);
        raise(8'h02);
        wr(REG_ALARM, 32'h0);
        rd_chk("hold", REG_ALARM, 32'h01);
        power_cycle();
        wr(REG_DISP, 32'h05);
        raise(8'h03);
        for (int k = 0; k < 3; k++) begin
            {scr, kup, kdn} <= {k != 0, 2'b11};
            cyc(k == 1 ? 8 : 18);
            {scr, kup, kdn} <= 3'b000;
            cyc(4);
            rd_chk("keys", REG_ALARM, k == 2 ? 32'h0 : 32'h03);
        end
        chk32("disp", 32'h05, {24'h0, disp});
        power_cycle();
        wr(REG_IRQ_MSK, 32'h1);
        raise(8'h05);
        cyc(2);
        chk1("irq", 1'b1, irq);
        rd_chk("irqst", REG_IRQ_ST, 32'h1);
        cyc(2);
        chk1("irq", 1'b0, irq);
        wr(REG_IRQ_MSK, 32'h0);
        pulse(1'b0);
        chk1("irq", 1'b0, irq);
        rd_chk("irqst", REG_IRQ_ST, 32'h2);
        report_and_stop();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
